// file: design/ecp_port.sv
// ECP parallel port: control registers, shared FIFO and peripheral handshakes
// Behaviour
// - Control bits 7,6 read one, unwritable
// - Direction ignored in modes 000, 010
// - Ack rising edge interrupts when enabled
// - Control bits drive handshake pins, some inverted
// - Mode 010 sends FIFO with compatible handshake
// - Mode 011 forward sends FIFO by ECP
// - Mode 011 reverse captures peripheral bytes
// - Test mode FIFO access, no transmission
// - Config A reads constant 10h
// - Config B: bit7 zero, bit6 irq level
// - Reverse busy high data, low command
// - Config B bits 5-3 report irq
// - Mode 011 drives data only after reverse acknowledge
// - Mode field bits 7-5; 000 resets FIFO
// - Mode 001 tri-states when direction set, reads pin levels
// - Address and data ports share FIFO order
// - Mode 111 exposes config A/B
// - ECR bit4 low enables fault-fall interrupt in mode 011
// - Service bit blocks DMA, software re-arms
// - Service bit sets on count or threshold
// - Full and empty flags track FIFO
// - Strobe loads data, paced by busy
// - One shared sixteen byte FIFO
`timescale 1ns/1ns
module ecp_port (
  input wire logic clk,
  input wire logic reset,
  input wire ecp_pkg::ecp_req_t req,
  output logic [7:0] rdata,
  input wire logic dma_ack,
  input wire logic dma_tc,
  output logic dma_req,
  output logic irq,
  input wire logic [2:0] irq_select,
  input wire logic [7:0] pd_in,
  output logic [7:0] pd_out,
  output logic pd_oe_n,
  output logic strobe_out,
  output logic autofeed_out,
  output logic init_out,
  output logic select_in_out,
  input wire logic ack_in,
  input wire logic busy_in,
  input wire logic fault_in,
  input wire logic perror_in,
  input wire logic select_in
);
  // Pin synchronisers
  logic [7:0] pd_s1_q, pd_s2_q;
  logic [4:0] pin_s1_q, pin_s2_q;
  logic ack_d1_q, busy_d1_q, fault_d1_q;
  logic ack_s, busy_s, fault_s, perror_s, sel_s;
  // Registers
  logic [7:0] data_q; // Data latch
  logic [5:0] ctrl_q; // Control bits 5..0
  logic [7:0] ecr_q; // Extended control
  logic [2:0] cfgb_low_q; // Writable config B bits
  logic ack_irq_q, fault_irq_q;
  // FIFO storage
  ecp_pkg::ecp_entry_t mem [ecp_pkg::FIFO_DEPTH];
  logic [3:0] wp_q, rp_q;
  logic [4:0] cnt_q;
  logic push, pop, full, empty;
  ecp_pkg::ecp_entry_t push_entry;
  // Handshake engine
  typedef enum {ECP_HS_IDLE, ECP_HS_SETUP, ECP_HS_STROBE, ECP_HS_WAIT, ECP_HS_RACK} ecp_hs_t;
  ecp_hs_t hs_q;
  logic [2:0] hs_cnt_q;
  logic [8:0] out_q; // Byte on the wire plus command tag
  logic hs_strobe_q, hs_hostack_q;
  ecp_pkg::ecp_mode_t mode;
  logic dir, fifo_wr, fifo_rd, fwd_send, rev_cap, dma_rd, dma_wr;

  // Two-stage pin synchronisers
  always_ff @(posedge clk) begin
    pd_s1_q <= pd_in;
    pd_s2_q <= pd_s1_q;
    pin_s1_q <= {ack_in, busy_in, fault_in, perror_in, select_in};
    pin_s2_q <= pin_s1_q;
    ack_d1_q <= ack_s;
    busy_d1_q <= busy_s;
    fault_d1_q <= fault_s;
  end
  assign {ack_s, busy_s, fault_s, perror_s, sel_s} = pin_s2_q;

  // Effective mode and direction
  always_comb begin
    mode = ecp_pkg::ecp_mode_t'(ecr_q[7:5]);
    dir = ctrl_q[ecp_pkg::CTRL_DIR];
    if (mode == ecp_pkg::ECP_MODE_SPP || mode == ecp_pkg::ECP_MODE_COMPAT_FIFO_PORT) begin
      dir = 1'b0;
    end
  end

  // FIFO access decode
  always_comb begin
    dma_wr = dma_ack && !dir;
    dma_rd = dma_ack && dir;
    fifo_wr = 1'b0;
    fifo_rd = 1'b0;
    push_entry = '{cmd: 1'b0, data: req.wdata};
    if (req.wr && req.addr == ecp_pkg::OFF_FIFO && (mode == ecp_pkg::ECP_MODE_COMPAT_FIFO_PORT
        || mode == ecp_pkg::ECP_MODE_ECP || mode == ecp_pkg::ECP_MODE_TEST)) begin
      fifo_wr = 1'b1;
    end
    if (req.wr && req.addr == ecp_pkg::OFF_DATA && mode == ecp_pkg::ECP_MODE_ECP && !dir) begin
      fifo_wr = 1'b1;
      push_entry.cmd = 1'b1;
    end
    if (dma_wr && !req.wr) begin
      fifo_wr = 1'b1;
      push_entry.data = pd_s2_q;
    end
    if (req.rd && req.addr == ecp_pkg::OFF_FIFO
        && (mode == ecp_pkg::ECP_MODE_ECP || mode == ecp_pkg::ECP_MODE_TEST)) begin
      fifo_rd = 1'b1;
    end
    if (dma_rd) begin
      fifo_rd = 1'b1;
    end
  end

  // Engine triggers
  assign fwd_send = (hs_q == ECP_HS_IDLE) ? 1'b0 : 1'b0;
  assign rev_cap = (hs_q == ECP_HS_RACK) && !ack_s && ack_d1_q && !full;
  assign push = (fifo_wr && !full) || rev_cap;
  assign pop = (fifo_rd && !empty) || (hs_q == ECP_HS_IDLE && !empty && !dir
    && (mode == ecp_pkg::ECP_MODE_COMPAT_FIFO_PORT || mode == ecp_pkg::ECP_MODE_ECP));
  assign full = (cnt_q == 5'(ecp_pkg::FIFO_DEPTH));
  assign empty = (cnt_q == 5'h00);

  // Shared FIFO storage
  always_ff @(posedge clk) begin
    if (push) begin
      if (rev_cap) begin
        mem[wp_q] <= '{cmd: !busy_s, data: pd_s2_q};
      end else begin
        mem[wp_q] <= push_entry;
      end
    end
  end

  // FIFO pointers; mode 000 holds it reset
  always_ff @(posedge clk) begin
    if (reset || mode == ecp_pkg::ECP_MODE_SPP) begin
      wp_q <= 4'h0;
      rp_q <= 4'h0;
      cnt_q <= 5'h00;
    end else begin
      if (push) begin
        wp_q <= wp_q + 4'h1;
      end
      if (pop) begin
        rp_q <= rp_q + 4'h1;
      end
      cnt_q <= cnt_q + {4'h0, push} - {4'h0, pop};
    end
  end

  // Control register and data latch
  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl_q <= ecp_pkg::CTRL_RESET;
      data_q <= 8'h00;
    end else if (req.wr) begin
      if (req.addr == ecp_pkg::OFF_CTRL) begin
        ctrl_q <= req.wdata[5:0];
      end
      if (req.addr == ecp_pkg::OFF_DATA && mode != ecp_pkg::ECP_MODE_ECP) begin
        data_q <= req.wdata;
      end
    end
  end

  // Extended control register and service bit
  always_ff @(posedge clk) begin
    if (reset) begin
      ecr_q <= ecp_pkg::ECR_RESET;
    end else begin
      if (req.wr && req.addr == ecp_pkg::OFF_ECR) begin
        ecr_q[7:2] <= req.wdata[7:2];
      end
      if (!ecr_q[ecp_pkg::ECR_SVC] && mode != ecp_pkg::ECP_MODE_SPP) begin
        if (ecr_q[ecp_pkg::ECR_DMA_ENABLE_BIT] ? dma_tc
            : (!dir ? (5'(ecp_pkg::FIFO_DEPTH) - cnt_q >= ecp_pkg::WRITE_THRESHOLD)
                    : (cnt_q >= ecp_pkg::READ_THRESHOLD))) begin
          ecr_q[ecp_pkg::ECR_SVC] <= 1'b1;
        end
      end
    end
  end

  // Config B writable low bits
  always_ff @(posedge clk) begin
    if (reset) begin
      cfgb_low_q <= ecp_pkg::CFGB_LOW_RESET;
    end else if (req.wr && req.addr == ecp_pkg::OFF_CFGB && mode == ecp_pkg::ECP_MODE_CFG) begin
      cfgb_low_q <= req.wdata[2:0];
    end
  end

  // Ack flag cleared by status read, fault flag by ECR read; set wins
  always_ff @(posedge clk) begin
    if (reset) begin
      ack_irq_q <= 1'b0;
      fault_irq_q <= 1'b0;
    end else begin
      if (ctrl_q[ecp_pkg::CTRL_ACKIE] && ack_s && !ack_d1_q) begin
        ack_irq_q <= 1'b1;
      end else if (req.rd && req.addr == ecp_pkg::OFF_STATUS) begin
        ack_irq_q <= 1'b0;
      end
      if (mode == ecp_pkg::ECP_MODE_ECP && !ecr_q[ecp_pkg::ECR_ERRDIS]
          && !fault_s && fault_d1_q) begin
        fault_irq_q <= 1'b1;
      end else if (req.rd && req.addr == ecp_pkg::OFF_ECR) begin
        fault_irq_q <= 1'b0;
      end
    end
  end

  // Interrupt and DMA request outputs
  always_ff @(posedge clk) begin
    if (reset) begin
      irq <= 1'b0;
      dma_req <= 1'b0;
    end else begin
      irq <= ack_irq_q || fault_irq_q || (ecr_q[ecp_pkg::ECR_SVC:ecp_pkg::ECR_SVC] == 1'b0
        && !ecr_q[ecp_pkg::ECR_DMA_ENABLE_BIT] && mode != ecp_pkg::ECP_MODE_SPP && 1'b0);
      dma_req <= ecr_q[ecp_pkg::ECR_DMA_ENABLE_BIT] && !ecr_q[ecp_pkg::ECR_SVC]
        && (dir ? !empty : !full) && mode != ecp_pkg::ECP_MODE_SPP;
    end
  end

  // Forward and reverse handshake engine
  always_ff @(posedge clk) begin
    if (reset) begin
      hs_q <= ECP_HS_IDLE;
      hs_cnt_q <= 3'h0;
      out_q <= 9'h000;
      hs_strobe_q <= 1'b0;
      hs_hostack_q <= 1'b0;
    end else begin
      case (hs_q)
        ECP_HS_IDLE: begin
          hs_strobe_q <= 1'b0;
          hs_hostack_q <= 1'b0;
          if (mode == ecp_pkg::ECP_MODE_ECP && dir) begin
            hs_q <= ECP_HS_RACK;
          end else if (pop && !fifo_rd) begin
            out_q <= {mem[rp_q].cmd, mem[rp_q].data};
            hs_q <= ECP_HS_SETUP;
          end
        end
        ECP_HS_SETUP: begin
          if (!busy_s) begin
            hs_strobe_q <= 1'b1;
            hs_cnt_q <= ecp_pkg::STROBE_CYCLES;
            hs_q <= ECP_HS_STROBE;
          end
        end
        ECP_HS_STROBE: begin
          if (hs_cnt_q == 3'h1) begin
            hs_strobe_q <= 1'b0;
            hs_q <= ECP_HS_WAIT;
          end
          hs_cnt_q <= hs_cnt_q - 3'h1;
        end
        ECP_HS_WAIT: begin
          if (!busy_s) begin
            hs_q <= ECP_HS_IDLE;
          end
        end
        ECP_HS_RACK: begin
          hs_hostack_q <= !full; // Host ready for a byte
          if (mode != ecp_pkg::ECP_MODE_ECP || !dir) begin
            hs_q <= ECP_HS_IDLE;
          end
        end
        default: begin
          hs_q <= ECP_HS_IDLE;
        end
      endcase
    end
  end

  // Pin drivers
  always_ff @(posedge clk) begin
    if (reset) begin
      pd_out <= 8'h00;
      pd_oe_n <= 1'b1;
      strobe_out <= 1'b1;
      autofeed_out <= 1'b1;
      init_out <= 1'b0;
      select_in_out <= 1'b1;
    end else begin
      pd_out <= (hs_q == ECP_HS_IDLE || mode == ecp_pkg::ECP_MODE_TEST)
        ? ((mode == ecp_pkg::ECP_MODE_TEST) ? mem[rp_q].data : data_q) : out_q[7:0];
      pd_oe_n <= dir || (mode == ecp_pkg::ECP_MODE_ECP && !perror_s);
      strobe_out <= !(ctrl_q[ecp_pkg::CTRL_STB] || hs_strobe_q);
      autofeed_out <= (mode == ecp_pkg::ECP_MODE_ECP)
        ? (dir ? !hs_hostack_q : !out_q[8]) : !ctrl_q[ecp_pkg::CTRL_AFD];
      init_out <= ctrl_q[ecp_pkg::CTRL_INIT];
      select_in_out <= !ctrl_q[ecp_pkg::CTRL_SEL];
    end
  end

  // Register read data, one cycle after the strobe
  always_ff @(posedge clk) begin
    if (reset) begin
      rdata <= 8'h00;
    end else if (req.rd) begin
      case (req.addr)
        ecp_pkg::OFF_DATA: rdata <= (mode == ecp_pkg::ECP_MODE_BIDIR) ? pd_s2_q : data_q;
        ecp_pkg::OFF_STATUS: rdata <= {!busy_s, ack_s, perror_s, sel_s, fault_s, 3'h7};
        ecp_pkg::OFF_CTRL: rdata <= {2'h3, ctrl_q};
        ecp_pkg::OFF_FIFO: begin
          if (mode == ecp_pkg::ECP_MODE_CFG) begin
            rdata <= ecp_pkg::CFGA_VALUE;
          end else begin
            rdata <= empty ? 8'h00 : mem[rp_q].data;
          end
        end
        ecp_pkg::OFF_CFGB: rdata <= (mode == ecp_pkg::ECP_MODE_CFG)
          ? {1'b0, irq, irq_select, cfgb_low_q} : 8'h00;
        ecp_pkg::OFF_ECR: rdata <= {ecr_q[7:2], full, empty};
        default: rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end
endmodule // ecp_port

// file: design/ecp_pkg.sv
// Package: register offsets, field positions, reset values and types of the ECP port
package ecp_pkg;
  // Register offsets on the host port
  localparam logic [10:0] OFF_DATA = 11'h000; // Data latch / address FIFO port
  localparam logic [10:0] OFF_STATUS = 11'h001; // Status of peripheral inputs
  localparam logic [10:0] OFF_CTRL = 11'h002; // Port control
  localparam logic [10:0] OFF_FIFO = 11'h400; // Shared FIFO port / config A
  localparam logic [10:0] OFF_CFGB = 11'h401; // Config B
  localparam logic [10:0] OFF_ECR = 11'h402; // Extended control
  // Modes
  typedef enum logic [2:0] {
    ECP_MODE_SPP = 3'h0,
    ECP_MODE_BIDIR = 3'h1,
    ECP_MODE_COMPAT_FIFO_PORT = 3'h2,
    ECP_MODE_ECP = 3'h3,
    ECP_MODE_EPP = 3'h4,
    ECP_MODE_RSVD = 3'h5,
    ECP_MODE_TEST = 3'h6,
    ECP_MODE_CFG = 3'h7
  } ecp_mode_t;
  // Control register fields
  localparam int CTRL_DIR = 5;
  localparam int CTRL_ACKIE = 4;
  localparam int CTRL_SEL = 3;
  localparam int CTRL_INIT = 2;
  localparam int CTRL_AFD = 1;
  localparam int CTRL_STB = 0;
  // Extended control fields
  localparam int ECR_ERRDIS = 4;
  localparam int ECR_DMA_ENABLE_BIT = 3;
  localparam int ECR_SVC = 2;
  // Reset values and constants
  localparam logic [5:0] CTRL_RESET = 6'h00;
  localparam logic [7:0] ECR_RESET = 8'h15; // SPP, fault irq off, service bit set
  localparam logic [7:0] CFGA_VALUE = 8'h10; // 8-bit implementation
  localparam logic [2:0] CFGB_LOW_RESET = 3'h7;
  localparam int FIFO_DEPTH = 16;
  localparam logic [4:0] WRITE_THRESHOLD = 5'h08;
  localparam logic [4:0] READ_THRESHOLD = 5'h08;
  localparam logic [2:0] STROBE_CYCLES = 3'h3; // Strobe low width in cycles
  // FIFO entry: byte plus command tag
  typedef struct packed {
    logic cmd;
    logic [7:0] data;
  } ecp_entry_t;
  // Host register bus request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [10:0] addr;
    logic [7:0] wdata;
  } ecp_req_t;
endpackage

// file: tb/ecp_port_properties.sv
// Checker: port-level assertions for the ECP port
`timescale 1ns/1ns
module ecp_port_chk (
  input wire logic clk,
  input wire logic reset,
  input wire ecp_pkg::ecp_req_t req,
  input wire logic [7:0] rdata,
  input wire logic irq,
  input wire logic [2:0] irq_select,
  input wire logic pd_oe_n,
  input wire logic strobe_out,
  input wire logic autofeed_out,
  input wire logic init_out,
  input wire logic select_in_out,
  input wire logic ack_in,
  input wire logic fault_in
);
  logic [3:0] ecr_q; // Shadow of mode and fault-off bit
  logic [4:0] ctl_q; // Shadow of ack enable and pin bits
  // Follow host writes to both control registers
  always_ff @(posedge clk) begin
    if (reset) begin
      ecr_q <= 4'h1;
      ctl_q <= 5'h00;
    end else if (req.wr && req.addr == ecp_pkg::OFF_ECR) begin
      ecr_q <= req.wdata[7:4];
    end else if (req.wr && req.addr == ecp_pkg::OFF_CTRL) begin
      ctl_q <= req.wdata[4:0];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  ctl_high_a: assert property (req.rd && req.addr == ecp_pkg::OFF_CTRL |=> rdata[7:6] == 2'h3)
    else $error("control top bits not one");
  dir_out_a: assert property (!$past(reset) && ecr_q[3:1] inside {3'h0, 3'h2}
    && $stable(ecr_q) |-> !pd_oe_n) else $error("data lines not driven");
  ack_irq_a: assert property ($rose(ack_in) && ctl_q[4] |-> ##[1:6] irq)
    else $error("no irq on ack rise");
  pin_map_a: assert property (!$past(reset) && ecr_q[3:1] == 3'h0 && $stable(ctl_q)
    && $stable(ecr_q) |-> {select_in_out, init_out, autofeed_out, strobe_out}
    == {~ctl_q[3], ctl_q[2], ~ctl_q[1:0]}) else $error("pins differ from control");
  cfg_a_a: assert property (req.rd && req.addr == ecp_pkg::OFF_FIFO && ecr_q[3:1] == 3'h7
    |=> rdata == ecp_pkg::CFGA_VALUE) else $error("config A value");
  cfg_b_a: assert property (req.rd && req.addr == ecp_pkg::OFF_CFGB && ecr_q[3:1] == 3'h7
    |=> rdata[7:3] == {1'b0, $past(irq), $past(irq_select)}) else $error("config B fields");
  spp_flush_a: assert property (req.wr && req.addr == ecp_pkg::OFF_ECR
    && req.wdata[7:5] == 3'h0 ##2 req.rd && req.addr == ecp_pkg::OFF_ECR |=> rdata[0])
    else $error("fifo not emptied");
  fault_irq_a: assert property (ecr_q == 4'h6 && $fell(fault_in) |-> ##[1:6] irq)
    else $error("no irq on fault fall");
endmodule // ecp_port_chk
bind ecp_port ecp_port_chk i_chk (.clk(clk), .reset(reset), .req(req), .rdata(rdata),
  .irq(irq), .irq_select(irq_select), .pd_oe_n(pd_oe_n), .strobe_out(strobe_out),
  .autofeed_out(autofeed_out), .init_out(init_out), .select_in_out(select_in_out),
  .ack_in(ack_in), .fault_in(fault_in));

// file: tb/ecp_periph.sv
// Peripheral model: busy handshake and log of received bytes
`timescale 1ns/1ns
module ecp_periph (
  input wire logic clk,
  input wire logic strobe_out,
  input wire logic autofeed_out,
  input wire logic [7:0] pd,
  input wire logic [3:0] hold,
  output logic busy_in
);
  logic strb_q; // Last strobe level
  logic [3:0] cnt_q; // Busy cycles left
  logic [8:0] log_q [$]; // Bytes, bit 8 set for command
  initial begin
    strb_q = 1'b1;
    cnt_q = 4'h0;
    busy_in = 1'b0;
  end
  // Latch on strobe assert, stay busy for hold plus one cycles
  always @(posedge clk) begin
    strb_q <= strobe_out;
    if (strb_q && !strobe_out) begin
      log_q.push_back({~autofeed_out, pd});
      busy_in <= 1'b1;
      cnt_q <= hold;
    end else if (cnt_q != 4'h0) begin
      cnt_q <= cnt_q - 4'h1;
    end else begin
      busy_in <= 1'b0;
    end
  end
endmodule // ecp_periph

// file: tb/testbench.sv
// Testbench: registers, FIFO and handshakes of the ECP port
`timescale 1ns/1ns
module testbench;
  logic clk, reset, irq, pd_oe_n, ack_in, busy_in, fault_in;
  logic strobe_out, autofeed_out, init_out, select_in_out;
  ecp_pkg::ecp_req_t req;
  logic [7:0] rdata, pd_out, rev_data, v;
  logic [2:0] irq_select;
  logic [3:0] hold;
  wire [7:0] pd_wire = pd_oe_n ? rev_data : pd_out; // Line level
  int fails, n_tests;
  ecp_port i_dut (.clk(clk), .reset(reset), .req(req), .rdata(rdata), .dma_ack(1'b0),
    .dma_tc(1'b0), .dma_req(), .irq(irq), .irq_select(irq_select), .pd_in(pd_wire),
    .pd_out(pd_out), .pd_oe_n(pd_oe_n), .strobe_out(strobe_out), .autofeed_out(autofeed_out),
    .init_out(init_out), .select_in_out(select_in_out), .ack_in(ack_in), .busy_in(busy_in),
    .fault_in(fault_in), .perror_in(1'b1), .select_in(1'b1));
  ecp_periph i_per (.clk(clk), .strobe_out(strobe_out), .autofeed_out(autofeed_out),
    .pd(pd_wire), .hold(hold), .busy_in(busy_in));
  // 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic conclude;
    $display("fails=%0d n_tests=%0d", fails, n_tests);
    if (fails == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string n, input logic [8:0] seen, input logic [8:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic wr(input logic [10:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    req <= '0;
  endtask
  task automatic rd(input logic [10:0] a, output logic [7:0] d);
    @(posedge clk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk);
    req <= '0;
    #1 d = rdata;
  endtask
  task automatic rchk(input string n, input logic [10:0] a, input logic [7:0] e);
    rd(a, v);
    chk(n, {1'b0, v}, {1'b0, e});
  endtask
  // Bounded waits
  task automatic wait_irq;
    for (int i = 0; i < 10 && irq !== 1'b1; i++) @(posedge clk);
  endtask
  task automatic wait_log(input int n);
    for (int i = 0; i < 2000 && i_per.log_q.size() < n; i++) @(posedge clk);
    if (i_per.log_q.size() < n) begin
      fails++;
      conclude();
    end
  endtask
  task automatic t_ctrl;
    rchk("ecr", 11'h402, 8'h15);
    rchk("ctrl", 11'h002, 8'hc0);
    wr(11'h002, 8'h3f);
    rchk("ctrl", 11'h002, 8'hff);
    chk("pins", {select_in_out, init_out, autofeed_out, strobe_out}, 9'h004);
    chk("oe", pd_oe_n, 1'b0);
    wr(11'h002, 8'h20);
    wr(11'h402, 8'h34);
    rev_data <= 8'ha5;
    repeat (3) @(posedge clk);
    rchk("data", 11'h000, 8'ha5);
    chk("oe", pd_oe_n, 1'b1);
    wr(11'h402, 8'h14);
  endtask
  task automatic t_irq;
    wr(11'h002, 8'h10);
    ack_in <= 1'b0;
    repeat (4) @(posedge clk);
    ack_in <= 1'b1;
    wait_irq();
    chk("ack irq", irq, 1'b1);
    rd(11'h001, v);
    repeat (3) @(posedge clk);
    chk("irq clr", irq, 1'b0);
    wr(11'h002, 8'h00);
    wr(11'h402, 8'h74);
    fault_in <= 1'b0;
    repeat (8) @(posedge clk);
    chk("fault off", irq, 1'b0);
    fault_in <= 1'b1;
    wr(11'h402, 8'h14);
    wr(11'h402, 8'h64);
    fault_in <= 1'b0;
    wait_irq();
    chk("fault irq", irq, 1'b1);
    rd(11'h402, v);
    fault_in <= 1'b1;
    wr(11'h402, 8'h14);
  endtask
  task automatic t_cfg;
    wr(11'h402, 8'hf4);
    rchk("cfg a", 11'h400, 8'h10);
    for (int s = 0; s < 8; s++) begin
      irq_select <= s[2:0];
      rd(11'h401, v);
      chk("cfg b", {4'h0, v[7:3]}, {6'h00, s[2:0]});
    end
    wr(11'h402, 8'h14);
  endtask
  task automatic t_fifo;
    wr(11'h402, 8'hd0);
    rchk("svc", 11'h402, 8'hd5);
    i_per.log_q.delete();
    for (int i = 0; i < 17; i++) wr(11'h400, 8'h40 + i[7:0]);
    rchk("full", 11'h402, 8'hd6);
    for (int i = 0; i < 16; i++) rchk("fifo", 11'h400, 8'h40 + i[7:0]);
    rchk("empty", 11'h402, 8'hd5);
    chk("no send", 9'(i_per.log_q.size()), 9'h000);
    wr(11'h400, 8'h11);
    wr(11'h402, 8'h14);
    rchk("flush", 11'h402, 8'h15);
  endtask
  task automatic t_fwd;
    wr(11'h402, 8'h74);
    i_per.log_q.delete();
    wr(11'h000, 8'h5a);
    wr(11'h400, 8'hc3);
    wr(11'h400, 8'h3c);
    wait_log(3);
    chk("cmd", i_per.log_q[0], 9'h15a);
    chk("dat", i_per.log_q[1], 9'h0c3);
    chk("dat", i_per.log_q[2], 9'h03c);
    wr(11'h402, 8'h14);
    hold <= 4'h9;
    wr(11'h402, 8'h54);
    i_per.log_q.delete();
    wr(11'h400, 8'h81);
    wr(11'h400, 8'h7e);
    wait_log(2);
    chk("cmp", i_per.log_q[0], 9'h081);
    chk("cmp", i_per.log_q[1], 9'h07e);
  endtask
  // Reverse capture of one peripheral byte in mode 011
  task automatic t_rev;
    wr(11'h402, 8'h14);
    repeat (40) @(posedge clk);
    wr(11'h002, 8'h20);
    wr(11'h402, 8'h74);
    rev_data <= 8'h96;
    repeat (4) @(posedge clk);
    chk("rev oe", pd_oe_n, 1'b1);
    ack_in <= 1'b0;
    repeat (4) @(posedge clk);
    ack_in <= 1'b1;
    repeat (4) @(posedge clk);
    rchk("rev ecr", 11'h402, 8'h74);
    rchk("rev byte", 11'h400, 8'h96);
    rchk("rev empty", 11'h402, 8'h75);
    wr(11'h402, 8'h14);
    wr(11'h002, 8'h00);
  endtask
  initial begin
    fails = 0;
    n_tests = 0;
    reset = 1'b1;
    req = '0;
    irq_select = 3'h0;
    ack_in = 1'b1;
    fault_in = 1'b1;
    rev_data = 8'h00;
    hold = 4'h1;
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    t_ctrl();
    t_irq();
    t_cfg();
    t_fifo();
    t_fwd();
    t_rev();
    conclude();
  end
endmodule // testbench
